//--- hw/ipm_pkg.sv
package ipm_pkg;
    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;      // Command and configuration
    localparam logic [7:0] STAT_OFS = 8'h04;      // Busy and fault summary
    localparam logic [7:0] SC_OFS = 8'h08;        // Sum of cells result
    localparam logic [7:0] TEMP_OFS = 8'h0C;      // Die temperature result
    localparam logic [7:0] VA_OFS = 8'h10;        // Analog supply result
    localparam logic [7:0] VD_OFS = 8'h14;        // Digital supply result
    // Control register field positions
    localparam int CTRL_GO_BIT = 0;               // Write 1 starts a command
    localparam int CTRL_RED_BIT = 1;              // Redundant variant
    localparam int CTRL_MODE_LSB = 4;             // ADC mode, 3 bits
    localparam int CTRL_PS_LSB = 8;               // Path select, 2 bits
    localparam int CTRL_FORCE_REDUNDANCY_FAIL_BIT = 12;            // Force failure
    // Status register field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FAULT_LSB = 4;            // One bit per parameter
    // Result reset value and fault code
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [11:0] FAULT_HI = 12'hFF0;
    localparam logic [15:0] RESULT_MAX = 16'hDFFF;
    // Per-parameter completion times, microseconds from command start, per mode (t1M..t4C)
    localparam int CLK_MHZ = 125;
    localparam int NUM_MODES = 8;
    // Completion times of each of the four results, then end of command
    localparam int T_US [NUM_MODES][5] = '{
        '{58, 104, 151, 198, 742},
        '{87, 163, 238, 314, 858},
        '{145, 279, 413, 547, 1556},
        '{261, 512, 762, 1012, 2022},
        '{494, 977, 1460, 1943, 2953},
        '{960, 1908, 2857, 3805, 4814},
        '{1890, 3770, 5649, 7529, 8538},
        '{29818, 59624, 89431, 119238, 134211}};
    // Bus side carrier
    typedef struct packed {
        logic go;
        logic redundant;
        logic [2:0] mode;
        logic [1:0] path_select;
        logic force_fail;
    } ipm_cmd_type;
endpackage

//--- hw/ipm_redundancy_check.sv
`timescale 1ns/1ps
// Compares primary and redundant machine results nibble by nibble
module ipm_redundancy_check (
    input wire logic [15:0] primary,
    input wire logic [15:0] shadow,
    input wire logic force_fail,
    output logic [15:0] result,
    output logic fault
);
    import ipm_pkg::*;
    logic [3:0] nib_miss; // One bit per mismatched nibble

    // Nibble mismatch flags, bit 3 covers bits 15..12
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nib_miss[i] = |(primary[i*4 +: 4] ^ shadow[i*4 +: 4]); // [R14]
        end
    end

    // Forced failure marks every nibble so the low nibble is never zero
    always_comb begin
        fault = force_fail || (nib_miss != 4'h0); // [R18]
        if (force_fail) begin
            result = {FAULT_HI, (nib_miss | 4'hF)}; // [R15]
        end else if (nib_miss != 4'h0) begin
            result = {FAULT_HI, nib_miss}; // [R12] [R15]
        end else begin
            result = primary;
        end
    end
endmodule

//--- hw/ipm_top.sv
`timescale 1ns/1ps
// Function
// R1: Convert four internal parameters, eight modes
// R2: Finish within mode dependent total time
// R3: Sum result is stack voltage thirty to one
// R4: Store sum result in first status group
// R5: Store die temperature in first status group
// R6: Analog first group, digital second group
// R7: Host sets path select 0/1 first
// R8: Redundant and plain variants take same time
// R9: Three primary machines plus one spare
// R10: Plain internal conversion never applies redundancy
// R11: Bit stream feeds both machines, compare
// R12: Mismatch writes fault code 0xFF0 high
// R13: Valid results lie within 0x0000..0xDFFF
// R14: Low nibble flags mismatched result nibbles
// R15: Fault low nibble never all zero
// R16: Spare machine checks one ADC path
// R17: Path select field chooses checked path (the spare always taps ADC1; select only enables the check)
// R18: Force failure bit fails every comparison
// R19: Internal parameters checked only with 00/01
// R20: Order sum, temperature, analog, digital
module ipm_top (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ADC1_BIT,
    input wire logic ADC2_BIT,
    input wire logic ADC3_BIT,
    output logic BUSY
);
    import ipm_pkg::*;

    typedef enum logic [1:0] {IDLE, CONVERT} ipm_state_type;

    // Cycles per microsecond at the core clock
    localparam int CYC_PER_US = CLK_MHZ;

    // Synchronised modulator bit streams (pin inputs)
    logic [2:0] mod_meta_q;
    logic [2:0] mod_sync_q;
    // Control fields
    ipm_cmd_type cfg_q, cfg_d;
    // Sequencer
    ipm_state_type state_q, state_d;
    logic [31:0] tick_q, tick_d;         // Cycles since command start
    logic [1:0] param_q, param_d;        // Parameter being converted
    logic red_act_q, red_act_d;          // Redundancy applies this command
    logic [2:0] mode_q, mode_d;          // Latched mode
    // Integrators: three primaries plus spare
    logic [15:0] prim_acc_q [3];
    logic [15:0] prim_acc_d [3];
    logic [15:0] spare_acc_q, spare_acc_d;
    // Results and faults
    logic [15:0] res_q [4];
    logic [15:0] res_d [4];
    logic [3:0] fault_q, fault_d;
    // Checker wiring
    logic [15:0] chk_result;
    logic chk_fault;
    logic [15:0] clamp_prim;
    logic [31:0] mark_cyc;
    logic mark_hit;
    logic bus_wr, bus_rd;
    logic [1:0] spare_src;

    // Two-stage synchroniser for the modulator streams
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mod_meta_q <= 3'h0;
            mod_sync_q <= 3'h0;
        end else begin
            mod_meta_q <= {ADC3_BIT, ADC2_BIT, ADC1_BIT};
            mod_sync_q <= mod_meta_q;
        end
    end

    assign bus_wr = PSEL && PENABLE && PWRITE;
    assign bus_rd = PSEL && !PWRITE;

    // Zero wait state slave; unmapped addresses error
    always_comb begin
        PREADY = 1'b1;
        PSLVERR = PSEL && PENABLE &&
            !(PADDR inside {CTRL_OFS, STAT_OFS, SC_OFS, TEMP_OFS, VA_OFS, VD_OFS});
    end

    // Read data captured in the setup cycle, held until the next read
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (bus_rd && !PENABLE) begin
            unique case (PADDR)
                CTRL_OFS: PRDATA <= {19'h0, cfg_q.force_fail, 2'h0, cfg_q.path_select, 1'b0,
                    cfg_q.mode, 2'h0, cfg_q.redundant, 1'b0};
                STAT_OFS: PRDATA <= {24'h0, fault_q, 3'h0, (state_q == CONVERT)};
                SC_OFS: PRDATA <= {16'h0, res_q[0]};
                TEMP_OFS: PRDATA <= {16'h0, res_q[1]};
                VA_OFS: PRDATA <= {16'h0, res_q[2]};
                VD_OFS: PRDATA <= {16'h0, res_q[3]};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration register next state; go self-clears
    always_comb begin
        cfg_d = cfg_q;
        cfg_d.go = 1'b0;
        if (bus_wr && PADDR == CTRL_OFS) begin
            cfg_d.go = PWDATA[CTRL_GO_BIT];
            cfg_d.redundant = PWDATA[CTRL_RED_BIT];
            cfg_d.mode = PWDATA[CTRL_MODE_LSB +: 3];
            cfg_d.path_select = PWDATA[CTRL_PS_LSB +: 2]; // [R17]
            cfg_d.force_fail = PWDATA[CTRL_FORCE_REDUNDANCY_FAIL_BIT]; // [R18]
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Completion time of the current parameter in cycles
    always_comb begin
        mark_cyc = 32'(T_US[mode_q][param_q]) * 32'(CYC_PER_US);
        mark_hit = (tick_q + 32'd1 >= mark_cyc);
    end

    // Spare machine follows ADC1 for internal parameters; selects 10/11 still
    // run it but no check is made
    assign spare_src = 2'd0; // [R16] [R19]

    // Clamp primary result into the legal range
    assign clamp_prim = (prim_acc_q[0] > RESULT_MAX) ? RESULT_MAX : prim_acc_q[0]; // [R13]

    ipm_redundancy_check u_check (
        .primary(clamp_prim),
        .shadow((spare_acc_q > RESULT_MAX) ? RESULT_MAX : spare_acc_q),
        .force_fail(cfg_q.force_fail),
        .result(chk_result),
        .fault(chk_fault)
    );

    // Sequencer and integrators next state
    always_comb begin
        state_d = state_q;
        tick_d = tick_q;
        param_d = param_q;
        red_act_d = red_act_q;
        mode_d = mode_q;
        prim_acc_d = prim_acc_q;
        spare_acc_d = spare_acc_q;
        res_d = res_q;
        fault_d = fault_q;
        unique case (state_q)
            IDLE: begin
                if (cfg_q.go) begin
                    state_d = CONVERT; // [R1]
                    tick_d = 32'd0;
                    param_d = 2'd0;
                    mode_d = cfg_q.mode; // [R1]
                    // Plain command never checks; path 10/11 disables check
                    red_act_d = cfg_q.redundant && !cfg_q.path_select[1]; // [R7] [R10] [R19]
                    fault_d = 4'h0;
                    for (int i = 0; i < 3; i++) begin
                        prim_acc_d[i] = 16'h0000;
                    end
                    spare_acc_d = 16'h0000;
                end
            end
            CONVERT: begin
                tick_d = tick_q + 32'd1;
                // Each ADC integrates its own stream; spare taps one path
                for (int i = 0; i < 3; i++) begin
                    prim_acc_d[i] = prim_acc_q[i] + {15'h0, mod_sync_q[i]}; // [R9]
                end
                spare_acc_d = spare_acc_q + {15'h0, mod_sync_q[spare_src]}; // [R11]
                if (param_q == 2'd3 &&
                    tick_q + 32'd1 >= 32'(T_US[mode_q][4]) * 32'(CYC_PER_US)) begin
                    state_d = IDLE; // [R2] [R8]
                end else if (mark_hit && tick_q + 32'd1 == mark_cyc) begin
                    // Store current parameter, compare if redundant
                    if (red_act_q) begin
                        res_d[param_q] = chk_result; // [R11] [R12]
                        fault_d[param_q] = chk_fault;
                    end else begin
                        res_d[param_q] = clamp_prim; // [R3] [R4] [R5] [R6]
                    end
                    prim_acc_d[0] = 16'h0000;
                    spare_acc_d = 16'h0000;
                    if (param_q != 2'd3) begin
                        param_d = param_q + 2'd1; // [R20]
                    end
                end
            end
            default: state_d = IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= IDLE;
            tick_q <= 32'd0;
            param_q <= 2'd0;
            red_act_q <= 1'b0;
            mode_q <= 3'd0;
            prim_acc_q <= '{default: 16'h0000};
            spare_acc_q <= 16'h0000;
            res_q <= '{default: RESULT_RST};
            fault_q <= 4'h0;
        end else begin
            state_q <= state_d;
            tick_q <= tick_d;
            param_q <= param_d;
            red_act_q <= red_act_d;
            mode_q <= mode_d;
            prim_acc_q <= prim_acc_d;
            spare_acc_q <= spare_acc_d;
            res_q <= res_d;
            fault_q <= fault_d;
        end
    end

    assign BUSY = (state_q == CONVERT);

    // Checks
    chk_plain_nofault: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R10]
        (state_q == CONVERT && !red_act_q) |-> fault_q == 4'h0)
        else $error("plain conversion raised fault");
    chk_fault_code: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R12]
        chk_fault |-> (chk_result[15:4] == FAULT_HI && chk_result[3:0] != 4'h0))
        else $error("bad fault code");
    chk_nonzero_nib: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R15]
        cfg_q.force_fail |-> chk_result[3:0] == 4'hF)
        else $error("forced fault nibble not set");
    chk_range_ok: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R13]
        !chk_fault |-> chk_result <= RESULT_MAX)
        else $error("result out of range");
    chk_force_fail: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R18]
        cfg_q.force_fail |-> chk_fault)
        else $error("force failure ignored");
    chk_start_busy: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R1]
        (state_q == IDLE && cfg_q.go) |=> BUSY)
        else $error("command did not start");
    chk_order_step: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R20]
        (BUSY && param_q != $past(param_q) && $past(BUSY)) |-> param_q == $past(param_q) + 2'd1)
        else $error("parameter order broken");
    chk_ps_high: assert property (@(posedge CORE_CLK) disable iff (!ARST_N) // [R19]
        (state_q == IDLE && cfg_q.go && cfg_q.path_select[1]) |=> !red_act_q)
        else $error("redundancy on illegal path");
    cov_plain: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $fell(BUSY) && !red_act_q);
    cov_red: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $fell(BUSY) && red_act_q);
    cov_forced: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $fell(BUSY) && fault_q == 4'hF);
endmodule

//--- testbench/ipm_adc_model.sv
`timescale 1ns/1ps
// Stand-in for the three analog modulators feeding the converter
module ipm_adc_model (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [2:0] noise,
    output logic [2:0] bits_q
);
    logic [2:0] bits_d; // Next modulator outputs
    // Modulator bit density comes from the bench, so results stay unknown
    always_comb begin
        bits_d = noise;
    end
    // Launch off the edge, held low in reset like an idle modulator
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bits_q <= 3'h0;
        end else begin
            bits_q <= bits_d;
        end
    end
endmodule

//--- testbench/tb_ipm_top.sv
`timescale 1ns/1ps
// Self-checking bench for the internal parameter measurement block
module tb_ipm_top;
    import ipm_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    logic [2:0] adc_bits;
    logic [2:0] noise = 3'h0;
    logic [31:0] rnd = 32'h00013269; // Fixed seed keeps runs repeatable
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int busy_cnt = 0;
    int t0 = 0;
    int n;

    ipm_top dut (.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ADC1_BIT(adc_bits[0]),
        .ADC2_BIT(adc_bits[1]), .ADC3_BIT(adc_bits[2]), .BUSY(busy));
    ipm_adc_model adc (.CORE_CLK(clk), .ARST_N(arst_n), .noise(noise), .bits_q(adc_bits));

    // 125 MHz core clock
    always #4 clk = ~clk;

    // Cycle count, busy length and fresh modulator noise every rising edge
    always @(posedge clk) begin
        cyc++;
        if (busy === 1'b1) begin
            busy_cnt++;
        end
        rnd = xorshift(rnd);
        noise <= rnd[2:0];
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // Whole command length in core cycles for one mode
    function automatic int conv_cycles(input int mode);
        return T_US[mode][4] * CLK_MHZ;
    endfunction

    // Forced mismatch flags every nibble, so the low nibble is all ones
    function automatic logic [31:0] forced_code();
        return {16'h0000, FAULT_HI, 4'hF};
    endfunction

    function automatic logic [31:0] ctrl_word(input logic red, input logic [2:0] mode,
        input logic [1:0] ps, input logic ff);
        logic [31:0] w;
        w = 32'h00000000;
        w[CTRL_GO_BIT] = 1'b1;
        w[CTRL_RED_BIT] = red;
        w[CTRL_MODE_LSB +: 3] = mode;
        w[CTRL_PS_LSB +: 2] = ps;
        w[CTRL_FORCE_REDUNDANCY_FAIL_BIT] = ff;
        return w;
    endfunction

    task automatic stop_test();
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            failures++;
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdat, output logic serr);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (k >= 100) begin
            failures++;
            stop_test();
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Wait until a given cycle count after the conversion started
    task automatic wait_to(input int c);
        while (cyc - t0 < c) begin
            @(posedge clk);
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Status and all four results clear after reset
        for (int i = 1; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h00000000, rd, err);
            chk("reset value", rd, 32'h00000000);
            chk("mapped error", {31'h0, err}, 32'h00000000);
        end
        // Random unmapped address is refused
        apb(1'b0, {1'b1, rnd[4:0], 2'b00}, 32'h00000000, rd, err);
        chk("unmapped error", {31'h0, err}, 32'h00000001);
        chk("unmapped data", rd, 32'h00000000);
        // Redundant command, second path, forced failure, fastest mode
        apb(1'b1, CTRL_OFS, ctrl_word(1'b1, 3'h0, 2'b01, 1'b1), rd, err);
        n = 0;
        while (busy !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            failures++;
            stop_test();
        end
        chk("busy rise", {31'h0, busy}, 32'h00000001);
        t0 = cyc;
        // Second start while busy must not restart the count
        apb(1'b1, CTRL_OFS, ctrl_word(1'b1, 3'h0, 2'b01, 1'b1), rd, err);
        apb(1'b0, STAT_OFS, 32'h00000000, rd, err);
        chk("status busy", {31'h0, rd[STAT_BUSY_BIT]}, 32'h00000001);
        // Results land one by one in order
        wait_to(10000);
        apb(1'b0, SC_OFS, 32'h00000000, rd, err);
        chk("sum result", rd, forced_code());
        apb(1'b0, TEMP_OFS, 32'h00000000, rd, err);
        chk("temp early", rd, 32'h00000000);
        wait_to(16000);
        apb(1'b0, TEMP_OFS, 32'h00000000, rd, err);
        chk("temp result", rd, forced_code());
        apb(1'b0, VA_OFS, 32'h00000000, rd, err);
        chk("analog early", rd, 32'h00000000);
        wait_to(21000);
        apb(1'b0, VA_OFS, 32'h00000000, rd, err);
        chk("analog result", rd, forced_code());
        apb(1'b0, VD_OFS, 32'h00000000, rd, err);
        chk("digital early", rd, 32'h00000000);
        n = 0;
        while (busy !== 1'b0 && n < 100000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100000) begin
            failures++;
            stop_test();
        end
        @(posedge clk);
        chk("busy length", busy_cnt, conv_cycles(0));
        apb(1'b0, VD_OFS, 32'h00000000, rd, err);
        chk("digital result", rd, forced_code());
        apb(1'b0, STAT_OFS, 32'h00000000, rd, err);
        chk("fault summary", rd & 32'h000000F1, 32'h000000F0);
        // Redundant start on the third path, second mode: runs with no check
        apb(1'b1, CTRL_OFS, ctrl_word(1'b1, 3'h1, 2'b10, 1'b0), rd, err);
        apb(1'b0, CTRL_OFS, 32'h00000000, rd, err);
        chk("ctrl readback", rd, 32'h00000212);
        apb(1'b0, STAT_OFS, 32'h00000000, rd, err);
        chk("third path busy", rd & 32'h000000F1, 32'h00000001);
        stop_test();
    end
endmodule
